// [sim/cec_sw_model.sv]
`timescale 1ns/100ps
// Software side: register strobes, command headers and context pulses
module cec_sw_model (
    input wire logic i_mclk,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [2:0] o_reg_sel,
    output logic [31:0] o_reg_wdata,
    output logic o_ctx_save,
    output logic o_ctx_restore,
    output logic [3:0] o_ctx_id,
    output logic o_cmd_valid,
    output logic [31:0] o_cmd_header,
    output logic o_cmd_pred_en,
    output logic o_pred_eval_value
);
    logic [3:0] q_cmd[$]; // Expected {class, skip}
    logic [31:0] q_rd[$];
    initial begin
        {o_reg_wr, o_reg_rd, o_reg_sel, o_reg_wdata, o_ctx_save, o_ctx_restore} = '0;
        {o_ctx_id, o_cmd_valid, o_cmd_header, o_cmd_pred_en, o_pred_eval_value} = '0;
    end
    // One-cycle strobe, then an idle edge so no signal is set twice per step
    task automatic wr(input logic [2:0] sel, input logic [31:0] d);
        @(posedge i_mclk);
        o_reg_wr <= 1'b1;
        o_reg_sel <= sel;
        o_reg_wdata <= d;
        @(posedge i_mclk);
        o_reg_wr <= 1'b0;
    endtask
    // Extra idle edge ends the step; read data stands until the bench samples it either way
    task automatic rd(input logic [2:0] sel, input logic [31:0] e);
        @(posedge i_mclk);
        o_reg_rd <= 1'b1;
        o_reg_sel <= sel;
        q_rd.push_back(e);
        @(posedge i_mclk);
        o_reg_rd <= 1'b0;
        @(posedge i_mclk);
    endtask
    task automatic cmd(input logic [31:0] h, input logic pen, input logic pev, input logic skip);
        @(posedge i_mclk);
        o_cmd_valid <= 1'b1;
        o_cmd_header <= h;
        o_cmd_pred_en <= pen;
        o_pred_eval_value <= pev;
        q_cmd.push_back({h[31:29], skip});
        @(posedge i_mclk);
        o_cmd_valid <= 1'b0;
    endtask
    // Restore lands two edges later, so wait before touching registers
    task automatic ctx(input logic save, input logic [3:0] id);
        @(posedge i_mclk);
        o_ctx_save <= save;
        o_ctx_restore <= ~save;
        o_ctx_id <= id;
        @(posedge i_mclk);
        {o_ctx_save, o_ctx_restore} <= 2'b00;
        repeat (3) @(posedge i_mclk);
    endtask
endmodule

// [sim/test_cec_exec_control.sv]
`timescale 1ns/100ps
module test_cec_exec_control;
    logic i_mclk, i_nrst, i_ts_toggle, i_ctx_valid, i_execlist_en;
    logic reg_wr, reg_rd, ctx_save, ctx_restore, cmd_valid, pred_en, pev, rd_d1, rd_d2;
    logic [2:0] reg_sel, o_cmd_class;
    logic [3:0] ctx_id;
    logic [31:0] wdata, hdr, o_reg_rdata, o_intr_ident_set, o_hang_count, v, ev, pe, cs;
    logic o_cmd_exec, o_cmd_skip, ce;
    logic [31:0] img[7];
    logic [31:0] hdrs[12] = '{32'h7b000000, 32'h78520000, 32'h12000000, 32'h72020000,
        32'h7a000000, 32'h18800000, 32'h05000000, 32'h1b000000, 32'h00000000,
        32'h01000000, 32'h61000000, 32'h41000000};
    logic [15:0] lfsr_state = 16'h4f65;
    int fail_count, samples_checked, intr_n;
    cec_sw_model sw_inst (.i_mclk(i_mclk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_sel(reg_sel), .o_reg_wdata(wdata), .o_ctx_save(ctx_save),
        .o_ctx_restore(ctx_restore), .o_ctx_id(ctx_id), .o_cmd_valid(cmd_valid),
        .o_cmd_header(hdr), .o_cmd_pred_en(pred_en), .o_pred_eval_value(pev));
    cec_exec_control cec_exec_control_inst (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(ce),
        .i_ts_toggle(i_ts_toggle), .i_ctx_valid(i_ctx_valid), .i_execlist_en(i_execlist_en),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_sel(reg_sel), .i_reg_wdata(wdata),
        .o_reg_rdata(o_reg_rdata), .i_ctx_save(ctx_save), .i_ctx_restore(ctx_restore),
        .i_ctx_id(ctx_id), .i_cmd_valid(cmd_valid), .i_cmd_header(hdr),
        .i_cmd_pred_en(pred_en), .i_pred_eval_value(pev), .o_cmd_exec(o_cmd_exec),
        .o_cmd_skip(o_cmd_skip), .o_cmd_class(o_cmd_class),
        .o_intr_ident_set(o_intr_ident_set), .o_hang_count(o_hang_count));
    initial begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic run_valid(input int n);
        @(posedge i_mclk);
        i_ctx_valid <= 1'b1;
        repeat (n) @(posedge i_mclk);
        i_ctx_valid <= 1'b0;
    endtask
    // Read data is sampled one idle cycle after the strobe, where it stands either way
    always @(posedge i_mclk) begin
        rd_d1 <= reg_rd;
        rd_d2 <= rd_d1;
    end
    always @(negedge i_mclk) begin
        if (rd_d2) check("rdata", o_reg_rdata, sw_inst.q_rd.pop_front());
        if ((o_cmd_exec | o_cmd_skip) !== 1'b0) begin
            ev = {28'h0, sw_inst.q_cmd.pop_front()};
            check("cmd", {o_cmd_class, o_cmd_skip, o_cmd_exec}, {ev[3:0], ~ev[0]});
        end
        if (o_intr_ident_set !== 32'h0) begin
            intr_n++;
            check("intr", o_intr_ident_set, 32'h40);
        end
    end
    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        {i_nrst, i_ts_toggle, i_ctx_valid, i_execlist_en, ce} = 5'b00011;
        repeat (20) @(posedge i_mclk);
        i_nrst <= 1'b1;
        // Reset values; count and index 7 ignore writes
        for (int i = 0; i < 8; i++) sw_inst.rd(i[2:0], (i == 0) ? 32'h1 : 32'h0);
        sw_inst.wr(3'h2, 32'h1234);
        sw_inst.wr(3'h7, 32'h1234);
        sw_inst.rd(3'h2, 32'h0);
        sw_inst.rd(3'h7, 32'h0);
        for (int i = 3; i < 7; i++) begin
            lfsr_state = lfsr_next(lfsr_state);
            sw_inst.wr(i[2:0], {lfsr_state, ~lfsr_state});
            sw_inst.rd(i[2:0], {lfsr_state, ~lfsr_state});
        end
        // Every command kind but predicate and skip commands under every pair of result bits
        for (int k = 0; k < 4; k++) begin
            pe = {31'h0, k[0]};
            cs = {31'h0, k[1]};
            sw_inst.wr(cec_pkg::REG_PRED_EVAL_RESULT, pe);
            sw_inst.wr(cec_pkg::REG_COND_SKIP_RESULT, cs);
            for (int i = 0; i < 12; i++) begin
                lfsr_state = lfsr_next(lfsr_state);
                sw_inst.cmd(hdrs[i], lfsr_state[0], 1'b0,
                    (i < 5 && lfsr_state[0]) ? ~pe[0] : cs[0]);
            end
        end
        // Predicate and skip commands; skip command is never itself dropped
        sw_inst.cmd(32'h06000000, 1'b0, 1'b0, 1'b1);
        sw_inst.wr(cec_pkg::REG_PRED_AUX_INPUT_TWO, 32'h1);
        sw_inst.cmd(32'h00800001, 1'b0, 1'b0, 1'b0);
        sw_inst.rd(cec_pkg::REG_COND_SKIP_RESULT, 32'h0);
        sw_inst.cmd(32'h06000000, 1'b0, 1'b0, 1'b0);
        sw_inst.cmd(32'h00800001, 1'b0, 1'b0, 1'b0);
        sw_inst.rd(cec_pkg::REG_PRED_EVAL_RESULT, 32'h0);
        sw_inst.rd(cec_pkg::REG_COND_SKIP_RESULT, 32'h1);
        // Plain source copies the predicate result bit
        sw_inst.cmd(32'h00800000, 1'b0, 1'b0, 1'b0);
        sw_inst.rd(cec_pkg::REG_COND_SKIP_RESULT, 32'h0);
        // Context image: control kept disabled so nothing counts meanwhile
        for (int i = 0; i < 7; i++) begin
            lfsr_state = lfsr_next(lfsr_state);
            img[i] = (i == 0) ? {lfsr_state[0], 31'h1} : {lfsr_state, lfsr_state};
            sw_inst.wr(i[2:0], img[i]);
        end
        sw_inst.ctx(1'b1, 4'h3);
        for (int i = 0; i < 7; i++) sw_inst.wr(i[2:0], (i == 0) ? 32'h1 : 32'h0);
        sw_inst.ctx(1'b0, 4'h3);
        for (int i = 0; i < 7; i++) sw_inst.rd(i[2:0], (i == 2 || i == 6) ? 32'h0 : img[i]);
        // Hang timer: clock mode, then timestamp mode
        intr_n = 0;
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_THRESHOLD, 32'h100);
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_CONTROL, 32'h80000000);
        run_valid(10);
        sw_inst.rd(cec_pkg::REG_HANG_TIMER_COUNT, 32'd10);
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_CONTROL, 32'h0);
        @(posedge i_mclk);
        i_ctx_valid <= 1'b1;
        repeat (5) begin
            @(posedge i_mclk) i_ts_toggle <= 1'b1;
            @(posedge i_mclk) i_ts_toggle <= 1'b0;
        end
        i_ctx_valid <= 1'b0;
        sw_inst.rd(cec_pkg::REG_HANG_TIMER_COUNT, 32'd15);
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_THRESHOLD, 32'd18);
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_CONTROL, 32'h80000000);
        run_valid(20);
        check("intr_n", intr_n, 32'd1);
        sw_inst.rd(cec_pkg::REG_HANG_TIMER_COUNT, 32'd16);
        @(posedge i_mclk) i_execlist_en <= 1'b0;
        run_valid(5);
        i_execlist_en <= 1'b1;
        sw_inst.rd(cec_pkg::REG_HANG_TIMER_COUNT, 32'd16);
        // Neither enable nor disable pattern: counter must hold
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_CONTROL, 32'h80000002);
        run_valid(5);
        sw_inst.rd(cec_pkg::REG_HANG_TIMER_COUNT, 32'd16);
        // Clock enable low freezes a counter that would otherwise reach the threshold
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_CONTROL, 32'h80000000);
        @(posedge i_mclk) ce <= 1'b0;
        run_valid(6);
        ce <= 1'b1;
        @(negedge i_mclk) check("count_out", o_hang_count, 32'd16);
        // Live count survives a save and restore of the context
        sw_inst.ctx(1'b1, 4'h5);
        sw_inst.ctx(1'b0, 4'h5);
        sw_inst.rd(cec_pkg::REG_HANG_TIMER_COUNT, 32'd16);
        @(negedge i_mclk) check("count_out", o_hang_count, 32'd16);
        sw_inst.wr(cec_pkg::REG_HANG_TIMER_CONTROL, 32'h1);
        sw_inst.rd(cec_pkg::REG_HANG_TIMER_COUNT, 32'h0);
        repeat (4) @(posedge i_mclk);
        tally_and_finish();
    end
endmodule

// [verilog/cec_ctx_store.sv]
`timescale 1ns/100ps
module cec_ctx_store #(
    parameter int WIDTH = cec_pkg::CTX_W,
    parameter int DEPTH = cec_pkg::CTX_DEPTH,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic i_re,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rdata;
    } cec_store_t;

    cec_store_t st;
    cec_store_t next_st;

    // Write port and registered read port
    always_comb begin
        next_st = st;
        if (i_we) begin
            next_st.mem[i_waddr] = i_wdata;
        end
        if (i_re) begin
            next_st.rdata = st.mem[i_raddr];
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
endmodule

// [verilog/cec_exec_control.sv]
`timescale 1ns/100ps
// Overview of operation
// - Header top three bits give the class; 000 is memory-interface class.
// - Control low 31 bits zero enables the hang timer counting.
// - Control low 31 bits equal one disables it and zeroes the counter.
// - Control bit 31 clear counts timestamp toggles, set counts every clock.
// - Counter equal to threshold with timer enabled raises identity bit 6 and clears counter.
// - Counter advances only with timer enabled, context valid, execution list on.
// - Control and threshold are saved and restored with the engine context.
// - The counter itself is never saved or restored.
// - A command whose predication check is true is dropped as a no-op.
// - Commands without an enable field, except the skip command, are checked against skip result.
// - Enabled explicit commands skip on predicate bit 0 clear; others but the skip command on skip bit 0 set.
// - Predicate and skip commands update their result registers; software may too.
// - Skip command derives its result from predicate result, and from second input when header bit 0 is set.
module cec_exec_control #(
    parameter int CTX_DEPTH = cec_pkg::CTX_DEPTH,
    parameter int CTX_AW = $clog2(CTX_DEPTH)
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_ts_toggle,
    input wire logic i_ctx_valid,
    input wire logic i_execlist_en,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [2:0] i_reg_sel,
    input wire logic [31:0] i_reg_wdata,
    output logic [31:0] o_reg_rdata,
    input wire logic i_ctx_save,
    input wire logic i_ctx_restore,
    input wire logic [CTX_AW-1:0] i_ctx_id,
    input wire logic i_cmd_valid,
    input wire logic [31:0] i_cmd_header,
    input wire logic i_cmd_pred_en,
    input wire logic i_pred_eval_value,
    output logic o_cmd_exec,
    output logic o_cmd_skip,
    output logic [2:0] o_cmd_class,
    output logic [31:0] o_intr_ident_set,
    output logic [31:0] o_hang_count
);
    cec_pkg::cec_state_t st;
    cec_pkg::cec_state_t next_st;
    logic [cec_pkg::CTX_W-1:0] ctx_rdata;
    logic [2:0] hdr_class;
    logic [5:0] hdr_opc;
    logic is_mem_iface;
    logic is_explicit;
    logic is_cond_skip_cmd;
    logic is_pred_eval_cmd;
    logic pred_true;
    logic wd_enabled;
    logic wd_disabled;
    logic wd_tick;

    // Header decode
    assign hdr_class = i_cmd_header[cec_pkg::CLASS_HI:cec_pkg::CLASS_LO];
    assign hdr_opc = i_cmd_header[cec_pkg::OPC_HI:cec_pkg::OPC_LO];
    assign is_mem_iface = (hdr_class == cec_pkg::CLASS_MEM_IFACE);
    assign is_cond_skip_cmd = is_mem_iface && (hdr_opc == cec_pkg::OPC_COND_SKIP);
    assign is_pred_eval_cmd = is_mem_iface && (hdr_opc == cec_pkg::OPC_PRED_EVAL);
    // Explicitly predicable set; batch and all others but the skip command fall to the skip result
    assign is_explicit = (is_mem_iface && hdr_opc == cec_pkg::OPC_REG_TO_MEM_STORE)
        || i_cmd_header[31:16] == cec_pkg::HDR_DRAW_LAUNCH
        || i_cmd_header[31:16] == cec_pkg::HDR_DEPTH_OP_STATE
        || i_cmd_header[31:16] == cec_pkg::HDR_COMPUTE_DISPATCH
        || i_cmd_header[31:16] == cec_pkg::HDR_PIPE_SYNC;

    // Skip command is exempt so a set skip result can still be cleared by command
    always_comb begin
        if (is_explicit && i_cmd_pred_en) begin
            pred_true = (st.pe[0] == 1'b0);
        end else if (is_cond_skip_cmd) begin
            pred_true = 1'b0;
        end else begin
            pred_true = (st.cs[0] == 1'b1);
        end
    end

    // Hang timer mode decode
    assign wd_enabled = (st.ctrl[30:0] == cec_pkg::WDOG_ENABLE_VAL);
    assign wd_disabled = (st.ctrl[30:0] == cec_pkg::WDOG_DISABLE_VAL);
    assign wd_tick = st.ctrl[cec_pkg::MODE_BIT] ? 1'b1 : i_ts_toggle;

    // Next state: restore beats command update, which beats a software write
    always_comb begin
        next_st = st;
        next_st.exec = 1'b0;
        next_st.skip = 1'b0;
        next_st.irq = 1'b0;
        next_st.rst_pend = i_ctx_restore;
        // Software writes; the counter is read-only
        if (i_reg_wr) begin
            case (i_reg_sel)
                cec_pkg::REG_HANG_TIMER_CONTROL: next_st.ctrl = i_reg_wdata;
                cec_pkg::REG_HANG_TIMER_THRESHOLD: next_st.thr = i_reg_wdata;
                cec_pkg::REG_PRED_EVAL_RESULT: next_st.pe = i_reg_wdata;
                cec_pkg::REG_COND_SKIP_RESULT: next_st.cs = i_reg_wdata;
                cec_pkg::REG_PRED_AUX_INPUT_ONE: next_st.a1 = i_reg_wdata;
                cec_pkg::REG_PRED_AUX_INPUT_TWO: next_st.a2 = i_reg_wdata;
                default: next_st.rdata = st.rdata;
            endcase
        end
        // Software reads, answered one cycle later
        if (i_reg_rd) begin
            case (i_reg_sel)
                cec_pkg::REG_HANG_TIMER_CONTROL: next_st.rdata = st.ctrl;
                cec_pkg::REG_HANG_TIMER_THRESHOLD: next_st.rdata = st.thr;
                cec_pkg::REG_HANG_TIMER_COUNT: next_st.rdata = st.cnt;
                cec_pkg::REG_PRED_EVAL_RESULT: next_st.rdata = st.pe;
                cec_pkg::REG_COND_SKIP_RESULT: next_st.rdata = st.cs;
                cec_pkg::REG_PRED_AUX_INPUT_ONE: next_st.rdata = st.a1;
                cec_pkg::REG_PRED_AUX_INPUT_TWO: next_st.rdata = st.a2;
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end
        // Command stage
        if (i_cmd_valid) begin
            next_st.cls = hdr_class;
            next_st.exec = !pred_true;
            next_st.skip = pred_true;
            if (!pred_true && is_pred_eval_cmd) begin
                next_st.pe = {31'h0, i_pred_eval_value};
            end
            if (!pred_true && is_cond_skip_cmd) begin
                // Header bit 0 picks the plain or combined source
                next_st.cs = {31'h0, i_cmd_header[0] ? (st.pe[0] ^ st.a2[0])
                    : st.pe[0]};
            end
        end
        // Context restore lands a cycle after the store read
        if (st.rst_pend) begin
            next_st.ctrl = ctx_rdata[159:128];
            next_st.thr = ctx_rdata[127:96];
            next_st.pe = ctx_rdata[95:64];
            next_st.cs = ctx_rdata[63:32];
            next_st.a1 = ctx_rdata[31:0];
        end
        // Hang timer; counter is live state only, left alone by restore
        if (wd_disabled) begin
            next_st.cnt = 32'h0000_0000;
        end else if (wd_enabled && st.cnt == st.thr) begin
            next_st.cnt = 32'h0000_0000;
            next_st.irq = 1'b1;
        end else if (wd_enabled && i_ctx_valid && i_execlist_en && wd_tick) begin
            next_st.cnt = st.cnt + 32'h0000_0001;
        end else begin
            next_st.cnt = st.cnt;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            st <= '0;
            st.ctrl <= cec_pkg::CTRL_RESET;
            st.thr <= cec_pkg::THR_RESET;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // Per-context image store; the counter is deliberately absent
    cec_ctx_store #(
        .WIDTH(cec_pkg::CTX_W),
        .DEPTH(CTX_DEPTH),
        .AW(CTX_AW)
    ) u_ctx_store (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_we(i_ctx_save),
        .i_waddr(i_ctx_id),
        .i_wdata({st.ctrl, st.thr, st.pe, st.cs, st.a1}),
        .i_re(i_ctx_restore),
        .i_raddr(i_ctx_id),
        .o_rdata(ctx_rdata)
    );

    // Outputs
    assign o_reg_rdata = st.rdata;
    assign o_cmd_exec = st.exec;
    assign o_cmd_skip = st.skip;
    assign o_cmd_class = st.cls;
    assign o_hang_count = st.cnt;
    always_comb begin
        o_intr_ident_set = 32'h0000_0000;
        o_intr_ident_set[cec_pkg::INTR_BIT] = st.irq;
    end

    // Checks
    a_class_decode: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && i_cmd_valid |=> o_cmd_class == $past(i_cmd_header[31:29]))
        else $error("command class not captured");
    a_enabled_counts: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && !st.rst_pend && st.ctrl == 32'h8000_0000 && i_ctx_valid && i_execlist_en
        && st.cnt != st.thr |=> st.cnt == $past(st.cnt) + 32'h1)
        else $error("enabled clock-mode timer did not advance");
    a_disable_zeroes: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && st.ctrl[30:0] == 31'h1 |=> st.cnt == 32'h0)
        else $error("disabled timer not zeroed");
    a_ts_mode_holds: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && st.ctrl[30:0] == 31'h0 && !st.ctrl[31] && !i_ts_toggle
        && st.cnt != st.thr |=> $stable(st.cnt))
        else $error("toggle-mode timer moved without a toggle");
    a_match_interrupt: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && st.ctrl[30:0] == 31'h0 && st.cnt == st.thr
        |=> o_intr_ident_set == 32'h0000_0040 && st.cnt == 32'h0)
        else $error("threshold match missed");
    a_no_ctx_holds: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && (!i_ctx_valid || !i_execlist_en) && st.cnt != st.thr
        && st.ctrl[30:0] != 31'h1 |=> $stable(st.cnt))
        else $error("timer advanced without valid context");
    a_other_mode_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && st.ctrl[30:1] != 30'h0 |=> $stable(st.cnt))
        else $error("timer moved in unknown mode");
    a_skip_exclusive: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !(o_cmd_exec && o_cmd_skip)
        && (!$past(i_ce) || (o_cmd_exec || o_cmd_skip) == $past(i_cmd_valid)))
        else $error("command neither or both executed and skipped");
    a_explicit_skip: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && i_cmd_valid && i_cmd_header[31:16] == 16'h7b00 && i_cmd_pred_en
        |=> o_cmd_skip == ($past(st.pe[0]) == 1'b0))
        else $error("draw predication wrong");
    a_other_skip: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && i_cmd_valid && i_cmd_header[31:23] == 9'h00a
        |=> o_cmd_skip == $past(st.cs[0]))
        else $error("batch return predication wrong");
    a_pred_update: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && !st.rst_pend && i_cmd_valid && i_cmd_header[31:23] == 9'h00c && !st.cs[0]
        |=> st.pe[0] == $past(i_pred_eval_value))
        else $error("predicate result not updated");
    a_restore_ctrl: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        i_ce && st.rst_pend |=> st.ctrl == $past(ctx_rdata[159:128]))
        else $error("control not restored");
endmodule

// [verilog/cec_pkg.sv]
package cec_pkg;
    // Header fields
    localparam int CLASS_HI = 31;
    localparam int CLASS_LO = 29;
    localparam int OPC_HI = 28;
    localparam int OPC_LO = 23;
    localparam logic [2:0] CLASS_MEM_IFACE = 3'h0;
    // Memory-interface opcodes
    localparam logic [5:0] OPC_NO_OPERATION = 6'h00;
    localparam logic [5:0] OPC_COND_SKIP = 6'h01;
    localparam logic [5:0] OPC_BATCH_RETURN = 6'h0a;
    localparam logic [5:0] OPC_PRED_EVAL = 6'h0c;
    localparam logic [5:0] OPC_REG_TO_MEM_STORE = 6'h24;
    localparam logic [5:0] OPC_BATCH_JUMP = 6'h31;
    localparam logic [5:0] OPC_COND_BATCH_RETURN = 6'h36;
    // Engine commands, matched on header bits 31:16
    localparam logic [15:0] HDR_DRAW_LAUNCH = 16'h7b00;
    localparam logic [15:0] HDR_DEPTH_OP_STATE = 16'h7852;
    localparam logic [15:0] HDR_COMPUTE_DISPATCH = 16'h7202;
    localparam logic [15:0] HDR_PIPE_SYNC = 16'h7a00;
    // Hang timer control fields
    localparam int MODE_BIT = 31;
    localparam logic [30:0] WDOG_ENABLE_VAL = 31'h0000_0000;
    localparam logic [30:0] WDOG_DISABLE_VAL = 31'h0000_0001;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] THR_RESET = 32'h0000_0000;
    localparam int INTR_BIT = 6;
    // Register indices
    localparam logic [2:0] REG_HANG_TIMER_CONTROL = 3'h0;
    localparam logic [2:0] REG_HANG_TIMER_THRESHOLD = 3'h1;
    localparam logic [2:0] REG_HANG_TIMER_COUNT = 3'h2;
    localparam logic [2:0] REG_PRED_EVAL_RESULT = 3'h3;
    localparam logic [2:0] REG_COND_SKIP_RESULT = 3'h4;
    localparam logic [2:0] REG_PRED_AUX_INPUT_ONE = 3'h5;
    localparam logic [2:0] REG_PRED_AUX_INPUT_TWO = 3'h6;
    // Saved context image: control, threshold, two results, first input
    localparam int CTX_W = 160;
    localparam int CTX_DEPTH = 16;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] thr;
        logic [31:0] cnt;
        logic [31:0] pe;
        logic [31:0] cs;
        logic [31:0] a1;
        logic [31:0] a2;
        logic [31:0] rdata;
        logic [2:0] cls;
        logic exec;
        logic skip;
        logic irq;
        logic rst_pend;
    } cec_state_t;
endpackage
